// *** design/asr_pkg.sv ***
// constants for the asynchronous sram host controller
package asr_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    // timing figures in ns
    localparam int ADDRESS_ACCESS_TIME_NS = 25;
    localparam int DESELECT_TO_FLOAT_TIME_NS = 12;
    localparam int MIN_CYCLE_TIME_NS = 25;
    localparam int WRITE_PULSE_WIDTH_NS = 19;
    localparam int WRITE_RECOVERY_WIDTH_NS = 6;
    localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;
    localparam int DATA_HOLD_AFTER_WRITE_NS = 5;
    localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
    // least times rounded up to cycles, at least one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int ACCESS_CYC = cyc_up(ADDRESS_ACCESS_TIME_NS);
    localparam int FLOAT_CYC = cyc_up(DESELECT_TO_FLOAT_TIME_NS);
    localparam int CYCLE_CYC = cyc_up(MIN_CYCLE_TIME_NS);
    localparam int PULSE_CYC = cyc_up(WRITE_PULSE_WIDTH_NS);
    localparam int RECOV_CYC = cyc_up(WRITE_RECOVERY_WIDTH_NS);
    localparam int SETUP_CYC = cyc_up(ADDRESS_SETUP_TO_WRITE_START_NS);
    localparam int HOLD_CYC = cyc_up((DATA_HOLD_AFTER_WRITE_NS > ADDRESS_HOLD_AFTER_WRITE_NS) ?
        DATA_HOLD_AFTER_WRITE_NS : ADDRESS_HOLD_AFTER_WRITE_NS);
    // three flops plus the agreement stage before data is usable
    localparam int SYNC_CYC = 4;
    localparam int CNT_W = 4;
    localparam logic [3:0] ALL_HIGH4 = 4'hF;
    typedef enum {ST_IDLE, ST_RSETUP, ST_RWAIT, ST_WSETUP, ST_WPULSE, ST_WHOLD, ST_FLOAT} asr_state_t;
endpackage

// *** design/asr_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module asr_sync #(
    parameter int W = 32
) (
    input wire logic clock,             // system clock
    input wire logic resetn,            // sync reset, active low
    input wire logic [W-1:0] din,       // asynchronous input
    output logic [W-1:0] dout           // filtered level
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    always_comb
    begin
        next_dout = dout;
        if (s2 == s3)
        begin
            next_dout = s3;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end
        else
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end
endmodule

// *** design/asr_host.sv ***
// host-side controller driving an asynchronous 128k x 32 sram
`timescale 1ns/100ps
// Function
// - read only with select low, output enable low, store strobe high
// - consecutive reads may keep select low and just change address
// - host sets select valid no later than the read address change
// - for select-started reads, address valid by select falling edge
// - write occurs during overlap of low store strobe and low select
// - between writes at least one control returns high then low
// - host keeps strobe and select low together for write pulse width
// - host keeps controlling signal high for write recovery width
// - address valid setup before write start, stable during write
// - data valid before write end, address valid before write end
// - host holds address and data after write end
// - cycle times apply per byte-wide die
module asr_host (
    input wire logic clock,                              // 40 MHz clock
    input wire logic resetn,                             // sync reset, active low
    input wire logic reqValid,                           // request strobe
    input wire logic reqWrite,                           // 1 write, 0 read
    input wire logic [asr_pkg::ADDR_W-1:0] reqAddr,      // word address
    input wire logic [asr_pkg::DATA_W-1:0] reqData,      // write data
    input wire logic [asr_pkg::LANES-1:0] reqLanes,      // byte lanes to access
    output logic reqReady,                               // idle, can take request
    output logic rspValid,                               // read data pulse
    output logic [asr_pkg::DATA_W-1:0] rspData,          // read data
    output logic [asr_pkg::ADDR_W-1:0] memAddr,          // sram address
    output logic [asr_pkg::LANES-1:0] die_select_n,      // per-die select, low active
    output logic storeStrobe_n,                          // write strobe, low active
    output logic outputEnable_n,                         // output drive enable, low active
    input wire logic [asr_pkg::DATA_W-1:0] memDataIn,    // data pins in
    output logic [asr_pkg::DATA_W-1:0] memDataOut,       // data pins out
    output logic memDataOe                               // high while host drives data
);
    asr_pkg::asr_state_t state;
    asr_pkg::asr_state_t next_state;
    logic [asr_pkg::CNT_W-1:0] count;
    logic [asr_pkg::CNT_W-1:0] next_count;
    logic next_reqReady;
    logic next_rspValid;
    logic [asr_pkg::DATA_W-1:0] next_rspData;
    logic [asr_pkg::ADDR_W-1:0] next_memAddr;
    logic [asr_pkg::LANES-1:0] next_die_select_n;
    logic next_storeStrobe_n;
    logic next_outputEnable_n;
    logic [asr_pkg::DATA_W-1:0] next_memDataOut;
    logic next_memDataOe;
    logic [asr_pkg::DATA_W-1:0] dataSync;
    logic [asr_pkg::LANES-1:0] lanes;
    logic [asr_pkg::LANES-1:0] next_lanes;

    // --------------------------------------------
    // data pin synchroniser
    // --------------------------------------------
    asr_sync #(
        .W(asr_pkg::DATA_W)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .din(memDataIn),
        .dout(dataSync)
    );

    // --------------------------------------------
    // cycle sequencer
    // --------------------------------------------
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_reqReady = reqReady;
        next_rspValid = 1'b0;
        next_rspData = rspData;
        next_memAddr = memAddr;
        next_die_select_n = die_select_n;
        next_storeStrobe_n = storeStrobe_n;
        next_outputEnable_n = outputEnable_n;
        next_memDataOut = memDataOut;
        next_memDataOe = memDataOe;
        if (count != '0)
        begin
            next_count = count - 1'b1;
        end
        case (state)
            asr_pkg::ST_IDLE:
            begin
                if (reqValid && reqReady)
                begin
                    next_reqReady = 1'b0;
                    next_memAddr = reqAddr;
                    // address set while select still high
                    next_count = asr_pkg::CNT_W'(asr_pkg::SETUP_CYC - 1);
                    if (reqWrite)
                    begin
                        next_memDataOut = reqData;
                        next_memDataOe = 1'b1;
                        next_outputEnable_n = 1'b1;
                        next_state = asr_pkg::ST_WSETUP;
                    end
                    else
                    begin
                        next_state = asr_pkg::ST_RSETUP;
                    end
                end
            end
            asr_pkg::ST_RSETUP:
            begin
                if (count == '0)
                begin
                    next_die_select_n = ~lanes;
                    next_storeStrobe_n = 1'b1;
                    next_outputEnable_n = 1'b0;
                    // access time plus sync and agreement stages
                    next_count = asr_pkg::CNT_W'(asr_pkg::ACCESS_CYC + asr_pkg::SYNC_CYC);
                    next_state = asr_pkg::ST_RWAIT;
                end
            end
            asr_pkg::ST_RWAIT:
            begin
                if (count == '0)
                begin
                    next_rspData = dataSync;
                    next_rspValid = 1'b1;
                    next_die_select_n = asr_pkg::ALL_HIGH4;
                    next_outputEnable_n = 1'b1;
                    next_count = asr_pkg::CNT_W'(asr_pkg::FLOAT_CYC);
                    next_state = asr_pkg::ST_FLOAT;
                end
            end
            asr_pkg::ST_WSETUP:
            begin
                if (count == '0)
                begin
                    // strobe-controlled write, select falls with it
                    next_die_select_n = ~lanes;
                    next_storeStrobe_n = 1'b0;
                    next_count = asr_pkg::CNT_W'(asr_pkg::PULSE_CYC - 1);
                    next_state = asr_pkg::ST_WPULSE;
                end
            end
            asr_pkg::ST_WPULSE:
            begin
                if (count == '0)
                begin
                    next_storeStrobe_n = 1'b1;
                    next_die_select_n = asr_pkg::ALL_HIGH4;
                    next_count = asr_pkg::CNT_W'(asr_pkg::HOLD_CYC - 1);
                    next_state = asr_pkg::ST_WHOLD;
                end
            end
            asr_pkg::ST_WHOLD:
            begin
                if (count == '0)
                begin
                    next_memDataOe = 1'b0;
                    next_count = asr_pkg::CNT_W'(asr_pkg::RECOV_CYC);
                    next_state = asr_pkg::ST_FLOAT;
                end
            end
            asr_pkg::ST_FLOAT:
            begin
                // recovery / float gap keeps per-die cycle time
                if (count == '0)
                begin
                    next_reqReady = 1'b1;
                    next_state = asr_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_state = asr_pkg::ST_IDLE;
            end
        endcase
    end

    // --------------------------------------------
    // lanes latched alongside the address
    // --------------------------------------------
    always_comb
    begin
        next_lanes = lanes;
        if (state == asr_pkg::ST_IDLE && reqValid && reqReady)
        begin
            next_lanes = reqLanes;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            state <= asr_pkg::ST_IDLE;
            count <= '0;
            lanes <= '0;
            reqReady <= 1'b1;
            rspValid <= 1'b0;
            rspData <= '0;
            memAddr <= '0;
            die_select_n <= asr_pkg::ALL_HIGH4;
            storeStrobe_n <= 1'b1;
            outputEnable_n <= 1'b1;
            memDataOut <= '0;
            memDataOe <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            lanes <= next_lanes;
            reqReady <= next_reqReady;
            rspValid <= next_rspValid;
            rspData <= next_rspData;
            memAddr <= next_memAddr;
            die_select_n <= next_die_select_n;
            storeStrobe_n <= next_storeStrobe_n;
            outputEnable_n <= next_outputEnable_n;
            memDataOut <= next_memDataOut;
            memDataOe <= next_memDataOe;
        end
    end
endmodule

// *** tb/asr_host_chk.sv ***
// pin-level checker for the sram host controller
`timescale 1ns/100ps
module asr_host_chk (
    input wire logic clock, // clock
    input wire logic resetn, // sync reset, low
    input wire logic rspValid, // read pulse
    input wire logic [16:0] memAddr, // address
    input wire logic [3:0] die_select_n, // selects
    input wire logic storeStrobe_n, // strobe
    input wire logic outputEnable_n, // output enable
    input wire logic [31:0] memDataOut, // data out
    input wire logic memDataOe // data drive
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence readOn;
        $fell(outputEnable_n) ##1 !outputEnable_n [*5];
    endsequence
    sequence wrOn;
        $fell(storeStrobe_n);
    endsequence
    read_combo_a: assert property (!outputEnable_n |-> storeStrobe_n && die_select_n != 4'hF)
        else $error("read controls wrong");
    read_time_a: assert property (readOn |=> rspValid && outputEnable_n)
        else $error("read data late");
    read_addr_a: assert property (!outputEnable_n |-> $stable(memAddr))
        else $error("address moved in read");
    write_pulse_a: assert property (wrOn |-> die_select_n != 4'hF ##1 storeStrobe_n && die_select_n == 4'hF)
        else $error("write pulse wrong");
    write_hold_a: assert property (wrOn |-> (memDataOe && $stable(memAddr) && $stable(memDataOut)) [*2])
        else $error("write hold wrong");
    write_recov_a: assert property ($rose(storeStrobe_n) |-> storeStrobe_n [*2])
        else $error("write recovery short");
    no_fight_a: assert property (memDataOe |-> outputEnable_n)
        else $error("host drives during read");
    float_gap_a: assert property ($rose(outputEnable_n) |=> !memDataOe [*2])
        else $error("no float gap");
endmodule
bind asr_host asr_host_chk chk_u (.clock(clock), .resetn(resetn), .rspValid(rspValid),
    .memAddr(memAddr), .die_select_n(die_select_n), .storeStrobe_n(storeStrobe_n),
    .outputEnable_n(outputEnable_n), .memDataOut(memDataOut), .memDataOe(memDataOe));

// *** tb/asr_sram_model.sv ***
// behavioural model of the four-die asynchronous sram
`timescale 1ns/100ps
module asr_sram_model (
    input wire logic [16:0] addr, // word address
    input wire logic [3:0] selN, // die selects, low
    input wire logic wrN, // store strobe, low
    input wire logic oeN, // output enable, low
    input wire logic [31:0] dIn, // level on data wires
    output logic [31:0] dq // die drive
);
    logic [31:0] mem [int];
    initial dq = 32'h0;
    for (genvar i = 0; i < 4; i++)
    begin : g_die
        wire wrAct = !selN[i] && !wrN;
        wire rdAct = !selN[i] && !oeN && wrN;
        always @(negedge wrAct)
            if (!$isunknown(addr))
                mem[addr][8*i+:8] = dIn[8*i+:8];
        always @(addr, rdAct)
        begin
            dq[8*i+:8] = ~dq[8*i+:8];
            if (rdAct)
                dq[8*i+:8] <= #(asr_pkg::ADDRESS_ACCESS_TIME_NS) mem[addr][8*i+:8];
        end
    end
endmodule

// *** tb/asr_host_bench.sv ***
// self-checking bench for the sram host controller
`timescale 1ns/100ps
`define ASR_CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fails++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module asr_host_bench;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic reqValid = 1'b0;
    logic reqWrite = 1'b0;
    logic [16:0] reqAddr = 17'h0;
    logic [31:0] reqData = 32'h0;
    logic [3:0] reqLanes = 4'h0;
    logic reqReady, rspValid, storeStrobe_n, outputEnable_n, memDataOe;
    logic [31:0] rspData, memDataIn, memDataOut, sramDq;
    logic [16:0] memAddr;
    logic [3:0] die_select_n;
    logic [31:0] seed = 32'h2;
    logic [31:0] shadow [int];
    logic [63:0] expQ [$];
    logic [63:0] e;
    int fails = 0;
    int checked = 0;
    assign memDataIn = memDataOe ? memDataOut : sramDq;
    initial forever #12.5 clock = ~clock;
    asr_host dut_u (.clock(clock), .resetn(resetn), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqAddr(reqAddr), .reqData(reqData), .reqLanes(reqLanes), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .memAddr(memAddr), .die_select_n(die_select_n),
        .storeStrobe_n(storeStrobe_n), .outputEnable_n(outputEnable_n), .memDataIn(memDataIn),
        .memDataOut(memDataOut), .memDataOe(memDataOe));
    asr_sram_model sram_u (.addr(memAddr), .selN(die_select_n), .wrN(storeStrobe_n),
        .oeN(outputEnable_n), .dIn(memDataIn), .dq(sramDq));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic test_done();
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic req(input logic w, input logic [16:0] a, input logic [31:0] d, input logic [3:0] l);
        int n;
        logic [31:0] m;
        m = {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
        reqValid <= 1'b1;
        reqWrite <= w;
        reqAddr <= a;
        reqData <= d;
        reqLanes <= l;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
        end
        while (reqReady !== 1'b1 && n < 40);
        reqValid <= 1'b0;
        if (reqReady !== 1'b1)
        begin
            fails++;
            test_done();
        end
        if (w)
            shadow[a] = (shadow[a] & ~m) | (d & m);
        else
            expQ.push_back({shadow[a] & m, m});
        @(posedge clock);
    endtask
    always @(posedge clock)
        if (resetn === 1'b1 && rspValid === 1'b1)
        begin
            if (expQ.size() == 0)
                `ASR_CHK("rspCount", 1'b0, 1'b1)
            else
            begin
                e = expQ.pop_front();
                `ASR_CHK("rspData", e[63:32], rspData & e[31:0])
            end
        end
    initial
    begin
        logic [16:0] a [8];
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        `ASR_CHK("idlePins", 8'hFE, {reqReady, die_select_n, storeStrobe_n, outputEnable_n, memDataOe})
        for (int i = 0; i < 8; i++)
        begin
            a[i] = 17'(rnd());
            req(1'b1, a[i], rnd(), 4'hF);
        end
        for (int i = 0; i < 8; i++)
            req(1'b0, a[i], 32'h0, 4'hF);
        for (int l = 1; l < 16; l++)
        begin
            req(1'b1, a[0], rnd(), 4'(l));
            req(1'b0, a[0], 32'h0, 4'(l));
            req(1'b0, a[0], 32'h0, 4'hF);
        end
        for (int n = 0; n < 20 && expQ.size() > 0; n++)
            @(posedge clock);
        if (expQ.size() > 0)
            fails++;
        test_done();
    end
endmodule
